// >>> hdl/isa_pkg.sv
// Shared types and constants for the I2C slave address, receive and transmit engine
`default_nettype none
package isa_pkg;
  localparam logic [3:0] ISA_CNT_ZERO  = 4'h0; // Bit counter idle value
  localparam logic [3:0] ISA_CNT_BYTE  = 4'h8; // Eight data rises seen
  localparam logic [3:0] ISA_CNT_ACK   = 4'h9; // Ninth (ack) rise seen
  localparam logic [4:0] ISA_HI_PREFIX = 5'h1e; // 10-bit high byte prefix
  localparam logic [7:0] ISA_MASK_RST  = 8'hff; // Address mask reset
  localparam logic [7:0] ISA_ADDR_RST  = 8'h00; // Own address reset
  localparam logic [7:0] ISA_BYTE_ZERO = 8'h00; // Empty byte
  localparam logic [7:0] ISA_ALL_BITS  = 8'hff; // Compare every bit
  localparam logic [7:0] ISA_SKIP_LSB  = 8'hfe; // Compare bits 7..1

  // Engine states
  typedef enum logic [2:0] {
    ISA_IDLE    = 3'b000,
    ISA_ADDR    = 3'b001,
    ISA_ADDR_LO = 3'b010,
    ISA_RX      = 3'b011,
    ISA_TX      = 3'b100
  } isa_state_t;

  // Static configuration from software
  typedef struct packed {
    logic       tenBitMode;
    logic       stretchEnable;
    logic       addressHoldEnable;
    logic       dataHoldEnable;
    logic       bufferOverwriteEnable;
    logic       startIrqEnable;
    logic       slaveCollisionDetectEnable;
    logic       ackValueSelect;
    logic [7:0] addressMask;
  } isa_ctrl_t;

  // One-cycle software strobes with their data
  typedef struct packed {
    logic       ownAddrWrite;
    logic [7:0] ownAddrData;
    logic       bufWrite;
    logic [7:0] bufWriteData;
    logic       bufRead;
    logic       clockReleaseSet;
    logic       irqFlagClear;
    logic       overflowClear;
    logic       busCollisionClear;
  } isa_cmd_t;

  // Status seen by software
  typedef struct packed {
    logic [7:0] dataBuffer;
    logic [7:0] ownAddress;
    logic       bufferFull;
    logic       receiveOverflow;
    logic       serialIrq;
    logic       updateAddress;
    logic       readWrite;
    logic       startSeen;
    logic       stopSeen;
    logic       ackTime;
    logic       masterAckStatus;
    logic       clockRelease;
    logic       busCollisionIrq;
  } isa_status_t;
endpackage
`default_nettype wire

// >>> hdl/isa_i2c_slave.sv
// I2C slave engine: address match, reception, transmission, clock stretching
`default_nettype none
module isa_i2c_slave
  import isa_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  sclClk,
  input  wire logic  sdaIn,
  input  wire isa_ctrl_t ctrl,
  input  wire isa_cmd_t  cmd,
  output var isa_status_t status,
  output logic       sclOut,
  output logic       sclOe,
  output logic       sdaOut,
  output logic       sdaOe
);

  // Link domain: sample and event toggle
  logic       riseTog_q;     // Flips on every SCL rise
  logic       riseBit_q;     // SDA caught at the rise
  // Pin and toggle synchronisers
  logic       sclMeta_q, sclSync_q, sclPrev_q;
  logic       sdaMeta_q, sdaSync_q, sdaPrev_q;
  logic       togMeta_q, togSync_q, togPrev_q;
  // Engine state
  isa_state_t state_q, state_d;
  logic [3:0] bitCnt_q;      // Rises seen in this byte
  logic [7:0] rxShift_q;     // Received bits
  logic [7:0] txShift_q;     // Bits still to send
  logic       ackPhase_q;    // We own the ack slot
  logic       nack_q;        // Hardware ack decision
  logic       hold_q;        // Software picks the ack
  logic       loMiss_q;      // Low address missed
  logic       priorMatch_q;  // Full 10-bit write match seen
  // Software-visible flops, then the SCL and SDA drive flops
  logic [7:0] dataBuf_q, ownAddr_q;
  logic       bf_q, ov_q, irq_q, ua_q, rw_q, start_q, stop_q;
  logic       ack_time_flag_q, mAck_q, ckp_q, bcol_q;
  logic       sclOe_q, sdaOe_q;

  // Masked compare of a received byte
  function automatic logic masked_eq(input logic [7:0] a, input logic [7:0] b,
                                     input logic [7:0] m, input logic [7:0] sel);
    masked_eq = (((a ^ b) & m & sel) == ISA_BYTE_ZERO);
  endfunction

  // Link-domain capture; the toggle qualifies the bit so
  // the bit itself is stable whenever the core reads it
  always_ff @(posedge sclClk or posedge rst)
  begin
    if (rst)
    begin
      riseTog_q <= 1'b0;
      riseBit_q <= 1'b0;
    end
    else
    begin
      riseTog_q <= ~riseTog_q;
      riseBit_q <= sdaIn; // Also the master ack sample
    end
  end

  // Two-flop synchronisers, then a history flop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {sclMeta_q, sclSync_q, sclPrev_q} <= 3'h7;
      {sdaMeta_q, sdaSync_q, sdaPrev_q} <= 3'h7;
      {togMeta_q, togSync_q, togPrev_q} <= 3'h0;
    end
    else
    begin
      sclMeta_q <= sclClk;
      sclSync_q <= sclMeta_q;
      sclPrev_q <= sclSync_q;
      sdaMeta_q <= sdaIn;
      sdaSync_q <= sdaMeta_q;
      sdaPrev_q <= sdaSync_q;
      togMeta_q <= riseTog_q;
      togSync_q <= togMeta_q;
      togPrev_q <= togSync_q;
    end
  end

  // Bus events in the core domain
  logic riseEvt, fallEvt, startDet, stopDet, fall8, fall9;
  assign riseEvt  = togSync_q ^ togPrev_q;
  assign fallEvt  = sclPrev_q & ~sclSync_q;
  assign startDet = sclSync_q & sclPrev_q & sdaPrev_q & ~sdaSync_q;
  assign stopDet  = sclSync_q & sclPrev_q & ~sdaPrev_q & sdaSync_q;
  assign fall8    = fallEvt && bitCnt_q == ISA_CNT_BYTE && state_q != ISA_IDLE;
  assign fall9    = fallEvt && bitCnt_q == ISA_CNT_ACK && state_q != ISA_IDLE;

  // Address decode
  logic hiMatch, addrOk, take, ovNow, holdByte, ackSent, txNack, coll;
  always_comb
  begin
    hiMatch = rxShift_q[7:3] == ISA_HI_PREFIX && rxShift_q[2:1] == ownAddr_q[2:1];
    addrOk  = 1'b0;
    if (state_q == ISA_ADDR_LO)
      addrOk = masked_eq(rxShift_q, ownAddr_q, ctrl.addressMask, ISA_ALL_BITS);
    else if (ctrl.tenBitMode)
      addrOk = hiMatch && (!rxShift_q[0] || priorMatch_q);
    else
      addrOk = masked_eq(rxShift_q, ownAddr_q, ctrl.addressMask, ISA_SKIP_LSB);
  end

  // Byte-level decisions
  assign take     = state_q == ISA_RX || ((state_q == ISA_ADDR || state_q == ISA_ADDR_LO) && addrOk);
  assign ovNow    = ov_q | (bf_q & ~ctrl.bufferOverwriteEnable);
  assign holdByte = state_q == ISA_RX ? ctrl.dataHoldEnable : ctrl.addressHoldEnable;
  assign ackSent  = hold_q ? ~ctrl.ackValueSelect : ~nack_q;
  assign txNack   = mAck_q;
  assign coll     = riseEvt && state_q == ISA_TX && bitCnt_q < ISA_CNT_BYTE && txShift_q[7] && !riseBit_q;

  // Event strobes and next state
  logic irqSet, ckpClr, uaSet, loadBuf, ovSet;
  always_comb
  begin
    state_d = state_q;
    irqSet  = 1'b0;
    ckpClr  = 1'b0;
    uaSet   = 1'b0;
    loadBuf = 1'b0;
    ovSet   = 1'b0;
    if (startDet)
    begin
      state_d = ISA_ADDR;
      irqSet  = ctrl.startIrqEnable;
    end
    else if (stopDet)
      state_d = ISA_IDLE;
    else if (coll)
      state_d = ISA_IDLE;
    else if (fall8 && state_q != ISA_TX)
    begin
      if (take)
      begin
        loadBuf = ~ovNow;
        ovSet   = bf_q & ~ctrl.bufferOverwriteEnable;
        irqSet  = holdByte;
        ckpClr  = holdByte;
      end
      else if (state_q == ISA_ADDR)
        state_d = ISA_IDLE; // Silent mismatch
    end
    else if (fall9 && state_q == ISA_TX)
    begin
      irqSet = 1'b1;
      ckpClr = ~txNack;
      if (txNack)
        state_d = ISA_IDLE;
    end
    else if (fall9 && ackPhase_q)
    begin
      irqSet = ackSent | loMiss_q;
      unique case (state_q)
        ISA_ADDR:
        begin
          if (!ackSent)
            state_d = ISA_IDLE;
          else if (rw_q)
          begin
            state_d = ISA_TX;
            ckpClr  = 1'b1;
          end
          else if (ctrl.tenBitMode)
          begin
            state_d = ISA_ADDR_LO;
            uaSet   = 1'b1;
          end
          else
          begin
            state_d = ISA_RX;
            ckpClr  = ctrl.stretchEnable;
          end
        end
        ISA_ADDR_LO:
        begin
          uaSet   = 1'b1;
          state_d = (loMiss_q || !ackSent) ? ISA_IDLE : ISA_RX;
        end
        ISA_RX:
        begin
          ckpClr = ackSent & ctrl.stretchEnable;
          if (!ackSent)
            state_d = ISA_IDLE;
        end
        default: state_d = ISA_IDLE;
      endcase
    end
  end

  // Engine state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_q <= ISA_IDLE;
    else
      state_q <= state_d;
  end

  // Bit counter and receive shifter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bitCnt_q  <= ISA_CNT_ZERO;
      rxShift_q <= ISA_BYTE_ZERO;
    end
    else if (startDet || stopDet || fall9)
      bitCnt_q <= ISA_CNT_ZERO;
    else if (riseEvt)
    begin
      bitCnt_q  <= bitCnt_q + 4'h1;
      rxShift_q <= {rxShift_q[6:0], riseBit_q};
    end
  end

  // Ack slot bookkeeping, latched at the 8th fall
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ackPhase_q <= 1'b0;
      nack_q     <= 1'b1;
      hold_q     <= 1'b0;
      loMiss_q   <= 1'b0;
    end
    else if (fall8 && state_q != ISA_TX && (take || state_q == ISA_ADDR_LO))
    begin
      ackPhase_q <= 1'b1;
      nack_q     <= ovNow | ~take;
      hold_q     <= take & holdByte;
      loMiss_q   <= ~take;
    end
    else if (fall9 || state_d == ISA_IDLE || startDet)
      ackPhase_q <= 1'b0;
  end

  // Prior full 10-bit write match
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      priorMatch_q <= 1'b0;
    else if (stopDet)
      priorMatch_q <= 1'b0;
    else if (fall8 && state_q == ISA_ADDR && ctrl.tenBitMode && !(hiMatch && rxShift_q[0]))
      priorMatch_q <= 1'b0;
    else if (fall9 && state_q == ISA_ADDR_LO && !loMiss_q && ackSent)
      priorMatch_q <= 1'b1;
  end

  // Transmit shifter: software load wins over a shift
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      txShift_q <= ISA_BYTE_ZERO;
    else if (cmd.bufWrite)
      txShift_q <= cmd.bufWriteData;
    else if (fallEvt && state_q == ISA_TX && bitCnt_q != ISA_CNT_ZERO && bitCnt_q < ISA_CNT_BYTE)
      txShift_q <= {txShift_q[6:0], 1'b0};
  end

  // Data buffer, full and overflow flags; set wins over clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dataBuf_q <= ISA_BYTE_ZERO;
      bf_q      <= 1'b0;
      ov_q      <= 1'b0;
    end
    else
    begin
      if (loadBuf)
        dataBuf_q <= rxShift_q;
      else if (cmd.bufWrite)
        dataBuf_q <= cmd.bufWriteData;
      bf_q <= loadBuf | cmd.bufWrite | (bf_q & ~cmd.bufRead);
      ov_q <= ovSet | (ov_q & ~cmd.overflowClear);
    end
  end

  // Serial irq flag: only software clears it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_q <= 1'b0;
    else
      irq_q <= irqSet | (irq_q & ~cmd.irqFlagClear);
  end

  // Own address and update flag
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ownAddr_q <= ISA_ADDR_RST;
      ua_q      <= 1'b0;
    end
    else
    begin
      if (cmd.ownAddrWrite)
        ownAddr_q <= cmd.ownAddrData;
      ua_q <= uaSet | (ua_q & ~cmd.ownAddrWrite);
    end
  end

  // Read/write flag, start and stop flags
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rw_q    <= 1'b0;
      start_q <= 1'b0;
      stop_q  <= 1'b0;
    end
    else
    begin
      if (fall8 && state_q == ISA_ADDR && addrOk)
        rw_q <= rxShift_q[0];
      if (startDet)
      begin
        start_q <= 1'b1;
        stop_q  <= 1'b0;
      end
      else if (stopDet)
      begin
        start_q <= 1'b0;
        stop_q  <= 1'b1;
      end
    end
  end

  // Ack-time flag spans the ack slot in hold modes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ack_time_flag_q <= 1'b0;
    else if (fall8 && take && holdByte && state_q != ISA_TX)
      ack_time_flag_q <= 1'b1;
    else if (fall9 || startDet || stopDet)
      ack_time_flag_q <= 1'b0;
  end

  // Master ack: caught on the ninth SCL rise of a transmitted byte
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mAck_q <= 1'b0;
    else if (riseEvt && state_q == ISA_TX && bitCnt_q == ISA_CNT_BYTE)
      mAck_q <= riseBit_q;
  end

  // Clock release bit; a hardware clear beats a software
  // set in the same cycle so a stretch is never skipped
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ckp_q <= 1'b1;
    else if (ckpClr)
      ckp_q <= 1'b0;
    else if (cmd.clockReleaseSet)
      ckp_q <= 1'b1;
  end

  // Slave bus collision flag
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bcol_q <= 1'b0;
    else
      bcol_q <= (coll & ctrl.slaveCollisionDetectEnable) | (bcol_q & ~cmd.busCollisionClear);
  end

  // SCL hold: never pull the line before the master has,
  // so a stretch cannot shorten an SCL high time
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sclOe_q <= 1'b0;
    else
      sclOe_q <= (~ckp_q | ua_q) & (~sclSync_q | sclOe_q);
  end

  // SDA drive: ack slot, else transmit bit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sdaOe_q <= 1'b0;
    else if (state_d == ISA_IDLE || startDet || stopDet)
      sdaOe_q <= 1'b0;
    else if (ackPhase_q)
      sdaOe_q <= ackSent;
    else
      sdaOe_q <= state_q == ISA_TX && bitCnt_q < ISA_CNT_BYTE && !txShift_q[7];
  end

  // Open-drain outputs only ever pull low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end
    else
    begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end
  end

  assign sclOe = sclOe_q;
  assign sdaOe = sdaOe_q;
  assign status = '{dataBuffer: dataBuf_q, ownAddress: ownAddr_q, bufferFull: bf_q,
                    receiveOverflow: ov_q, serialIrq: irq_q, updateAddress: ua_q,
                    readWrite: rw_q, startSeen: start_q, stopSeen: stop_q,
                    ackTime: ack_time_flag_q, masterAckStatus: mAck_q, clockRelease: ckp_q,
                    busCollisionIrq: bcol_q};

  // Checks on the core domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence readAckDone;
    fall9 && ackPhase_q && state_q == ISA_ADDR && rw_q && ackSent;
  endsequence

  ua_holds_scl_a: assert property (ua_q && !sclSync_q && !cmd.ownAddrWrite |=> sclOe_q)
    else $error("update flag did not hold SCL");
  ua_write_clr_a: assert property (cmd.ownAddrWrite && !uaSet |=> !ua_q)
    else $error("own address write left update flag set");
  start_flag_a: assert property (startDet && ctrl.startIrqEnable |=> start_q && irq_q)
    else $error("start not flagged");
  bf_read_clr_a: assert property (cmd.bufRead && !loadBuf && !cmd.bufWrite |=> !bf_q)
    else $error("buffer read kept full flag");
  tx_load_a: assert property (cmd.bufWrite |=> txShift_q == $past(cmd.bufWriteData))
    else $error("transmit shifter not loaded");
  // A software release one cycle after the ack is legal, so the
  // second cycle also accepts the release that just landed
  read_stretch_a: assert property (readAckDone |=> state_q == ISA_TX && !ckp_q
    ##1 (!ckp_q || $past(cmd.clockReleaseSet)))
    else $error("read request did not stretch");
  hold_stop_a: assert property (fall8 && take && holdByte && state_q != ISA_TX |=> !ckp_q && irq_q && ack_time_flag_q)
    else $error("hold mode did not stop at 8th fall");
  tx_nack_end_a: assert property (fall9 && state_q == ISA_TX && mAck_q |=> state_q == ISA_IDLE && irq_q)
    else $error("master nack did not end transfer");
  coll_flag_a: assert property (coll && ctrl.slaveCollisionDetectEnable |=> bcol_q && state_q == ISA_IDLE)
    else $error("collision not handled");
  scl_hold_low_a: assert property ($rose(sclOe_q) |-> $past(!sclSync_q))
    else $error("SCL pulled while high");
endmodule
`default_nettype wire

// >>> verif/isa_i2c_master.sv
// Behavioural I2C bus master driving the slave engine's bus side
`default_nettype none
module isa_i2c_master
(
  input  wire logic tck,
  input  wire logic sclOeDev,
  input  wire logic sdaOeDev,
  output logic      sclWire,
  output logic      sdaWire,
  output logic      stuck
);
  timeunit 1ns;
  timeprecision 1ps;

  logic sclOeM; // Master pulls SCL low
  logic sdaOeM; // Master pulls SDA low

  // Open-drain wires with pull-ups: released means high
  assign sclWire = !(sclOeM || sclOeDev);
  assign sdaWire = !(sdaOeM || sdaOeDev);

  initial
  begin
    sclOeM = 1'b0;
    sdaOeM = 1'b0;
    stuck  = 1'b0;
  end

  // Half bit time, well above the slave's synchroniser delay
  task automatic half();
    repeat (70) @(posedge tck);
  endtask

  // Release SCL and wait out any stretch; bounded so a held clock is seen
  task automatic rise();
    sclOeM = 1'b0;
    for (int i = 0; i < 8000 && !sclWire; i++) @(posedge tck);
    if (!sclWire) stuck = 1'b1;
    half();
  endtask

  // Pull SCL low; SDA moves only later so no false Start or Stop is seen
  task automatic fall();
    sclOeM = 1'b1;
    repeat (35) @(posedge tck);
  endtask

  task automatic start();
    sdaOeM = 1'b1;
    half();
    fall();
  endtask

  // Repeated Start, needed before a 10-bit read
  task automatic restart();
    sdaOeM = 1'b0;
    half();
    rise();
    sdaOeM = 1'b1;
    half();
    fall();
  endtask

  task automatic stop();
    sdaOeM = 1'b1;
    half();
    rise();
    sdaOeM = 1'b0;
    half();
  endtask

  // Eight bits, MSB first, ending just after the 8th fall
  task automatic wrBits(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      sdaOeM = !b[i];
      half();
      rise();
      fall();
    end
    sdaOeM = 1'b0;
  endtask

  // Ninth clock: sample the slave's answer, 0 means acknowledged
  task automatic ackSlot(output logic a);
    half();
    rise();
    a = sdaWire;
    fall();
  endtask

  // Clock a byte out of the slave; jam holds SDA low to force a collision
  task automatic rdBits(input logic jam, input logic nak, output logic [7:0] b);
    sdaOeM = jam;
    for (int i = 7; i >= 0; i--)
    begin
      half();
      rise();
      b[i] = sdaWire;
      fall();
    end
    sdaOeM = !nak;
    half();
    rise();
    fall();
    sdaOeM = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verif/test_i2c_slave_addr_rx_tx.sv
// Self-checking bench for the I2C slave engine
`default_nettype none
module test_i2c_slave_addr_rx_tx
  import isa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;        // Core clock
  logic        rst;        // Core reset
  logic        tck;        // Master's bit-timing clock
  isa_ctrl_t   ctrl;       // Software configuration
  isa_cmd_t    cmd;        // Software strobes
  isa_status_t status;     // Software-visible status
  logic        sclOe;      // Slave holds SCL
  logic        sdaOe;      // Slave pulls SDA
  logic        sclW;       // SCL wire level
  logic        sdaW;       // SDA wire level
  logic        stuck;      // SCL never came back
  logic        sclLvl;     // Level the slave drives on SCL
  logic        sdaLvl;     // Level the slave drives on SDA
  logic        a;          // Sampled ack bit
  logic [7:0]  d;          // Random data
  logic [7:0]  rb;         // Byte read back
  int          n_mismatch; // Mismatches
  int          compares;   // Comparisons

  always #50 clk = ~clk;
  initial
  begin
    tck = 1'b0;
    #2.5;
    forever #6 tck = ~tck;
  end

  isa_i2c_slave dut (.clk(clk), .rst(rst), .sclClk(sclW), .sdaIn(sdaW), .ctrl(ctrl), .cmd(cmd),
    .status(status), .sclOut(sclLvl), .sclOe(sclOe), .sdaOut(sdaLvl), .sdaOe(sdaOe));
  isa_i2c_master m (.tck(tck), .sclOeDev(sclOe), .sdaOeDev(sdaOe), .sclWire(sclW), .sdaWire(sdaW),
    .stuck(stuck));

  // Expected address bytes
  function automatic logic [7:0] ab(input logic [6:0] a7, input logic rw);
    return {a7, rw};
  endfunction
  function automatic logic [7:0] hb(input logic [9:0] a10, input logic rw);
    return {ISA_HI_PREFIX, a10[9:8], rw};
  endfunction

  // Strobe builder: 0 own address, 1 buffer write, 2 irq clear+read, 3 release, else clear all
  function automatic isa_cmd_t cm(input int k, input logic [7:0] v);
    cm = '0;
    case (k)
      0: {cm.ownAddrWrite, cm.ownAddrData} = {1'b1, v};
      1: {cm.bufWrite, cm.bufWriteData} = {1'b1, v};
      2: {cm.irqFlagClear, cm.bufRead} = 2'b11;
      3: cm.clockReleaseSet = 1'b1;
      default: {cm.overflowClear, cm.busCollisionClear, cm.bufRead, cm.irqFlagClear} = 4'hf;
    endcase
  endfunction

  // One-cycle strobe, driven on falling edges
  task automatic sw(input isa_cmd_t c);
    @(negedge clk) cmd = c;
    @(negedge clk) cmd = '0;
  endtask

  // Let synchronisers and status settle after a bus event
  task automatic w();
    repeat (8) @(negedge clk);
  endtask

  // Wide enough for every packed group of status bits compared below
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic results();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog: the whole sequence needs far less than this
  initial
  begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    results();
  end

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    cmd = '0;
    ctrl = '{addressMask: ISA_MASK_RST, default: 1'b0};
    n_mismatch = 0;
    compares = 0;
    d = 8'($urandom(27948));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    w();
    chk({status.clockRelease, status.ownAddress}, {1'b1, ISA_ADDR_RST}, "reset release");
    // 7-bit write, then an overflowing byte
    ctrl.startIrqEnable = 1'b1;
    sw(cm(0, 8'h52));
    chk(status.ownAddress, 8'h52, "own addr");
    m.start();
    w();
    chk({status.startSeen, status.serialIrq}, 2'b11, "start");
    @(negedge clk) ctrl.startIrqEnable = 1'b0;
    sw(cm(2, 0));
    m.wrBits(ab(7'h29, 0));
    m.ackSlot(a);
    w();
    chk(a, 0, "addr ack");
    chk(status.dataBuffer, ab(7'h29, 0), "addr buf");
    chk({status.readWrite, status.serialIrq}, 2'b01, "addr rw irq");
    sw(cm(2, 0));
    chk(status.bufferFull, 0, "bf read");
    d = 8'($urandom);
    m.wrBits(d);
    m.ackSlot(a);
    w();
    chk({a, status.dataBuffer}, {1'b0, d}, "data");
    m.wrBits(~d);
    m.ackSlot(a);
    w();
    chk({a, status.receiveOverflow, status.dataBuffer}, {2'b11, d}, "overflow");
    m.stop();
    w();
    chk(status.stopSeen, 1, "stop");
    sw(cm(4, 0));
    // Mismatch, then the same byte matched through the mask
    for (int k = 0; k < 2; k++)
    begin
      @(negedge clk) ctrl.addressMask = k ? 8'hf9 : ISA_MASK_RST;
      m.start();
      m.wrBits(8'h56);
      m.ackSlot(a);
      w();
      chk({a, status.serialIrq, status.dataBuffer}, {!k[0], k[0], k ? 8'h56 : d}, "mask");
      m.stop();
      sw(cm(2, 0));
    end
    @(negedge clk) ctrl.addressMask = ISA_MASK_RST;
    // Stretch after a received byte
    @(negedge clk) ctrl.stretchEnable = 1'b1;
    m.start();
    m.wrBits(8'h52);
    m.ackSlot(a);
    w();
    chk({status.clockRelease, sclOe}, 2'b01, "stretch");
    sw(cm(2, 0));
    sw(cm(3, 0));
    w();
    chk(sclOe, 0, "released");
    m.stop();
    @(negedge clk) ctrl.stretchEnable = 1'b0;
    // 7-bit read, LSB of the address is the read bit
    m.start();
    m.wrBits(8'h53);
    m.ackSlot(a);
    w();
    chk({a, status.readWrite, status.clockRelease, sclOe}, 4'h5, "read addr");
    chk(status.dataBuffer, 8'h53, "read buf");
    for (int k = 0; k < 2; k++)
    begin
      d = 8'($urandom);
      sw(cm(2, 0));
      sw(cm(1, d));
      sw(cm(3, 0));
      m.rdBits(0, k[0], rb);
      w();
      chk(rb, d, "tx byte");
      chk({status.masterAckStatus, status.serialIrq}, {k[0], 1'b1}, "tx ack");
      chk({status.clockRelease, sclOe}, {k[0], !k[0]}, "tx hold");
    end
    m.stop();
    sw(cm(2, 0));
    // Address hold with software-chosen answer
    @(negedge clk) ctrl.addressHoldEnable = 1'b1;
    for (int v = 0; v < 2; v++)
    begin
      @(negedge clk) ctrl.ackValueSelect = v[0];
      m.start();
      m.wrBits(8'h52);
      w();
      chk({status.serialIrq, status.clockRelease, status.ackTime, sclOe}, 4'hb, "hold");
      sw(cm(2, 0));
      sw(cm(3, 0));
      m.ackSlot(a);
      w();
      chk({a, status.serialIrq}, {v[0], !v[0]}, "hold ack");
      m.stop();
      sw(cm(2, 0));
    end
    // Data hold with overwrite: a full buffer is replaced and still acked
    @(negedge clk)
      ctrl = '{dataHoldEnable: 1'b1, bufferOverwriteEnable: 1'b1, addressMask: ISA_MASK_RST,
               default: 1'b0};
    d = 8'($urandom);
    m.start();
    m.wrBits(8'h52);
    m.ackSlot(a);
    m.wrBits(d);
    w();
    chk({status.clockRelease, status.ackTime, sclOe, status.dataBuffer}, {3'h3, d}, "data hold");
    sw(cm(2, 0));
    sw(cm(3, 0));
    m.ackSlot(a);
    w();
    chk({a, status.serialIrq, status.ackTime, status.receiveOverflow}, 4'h4, "data hold ack");
    m.stop();
    sw(cm(2, 0));
    @(negedge clk) ctrl = '{tenBitMode: 1'b1, addressMask: ISA_MASK_RST, default: 1'b0};
    // 10-bit: matching and failing low byte, read after a full match
    for (int k = 0; k < 2; k++)
    begin
      sw(cm(0, 8'h04));
      m.start();
      m.wrBits(hb(10'h2a5, 0));
      m.ackSlot(a);
      w();
      chk({a, status.updateAddress, sclOe}, 3'h3, "hi byte");
      sw(cm(2, 0));
      sw(cm(0, 8'ha5));
      w();
      chk({status.updateAddress, sclOe}, 2'b00, "ua clear");
      m.wrBits(k ? 8'ha4 : 8'ha5);
      m.ackSlot(a);
      w();
      chk({a, status.serialIrq, status.updateAddress, sclOe}, {k[0], 3'h7}, "lo byte");
      sw(cm(2, 0));
      sw(cm(0, 8'h04));
      w();
      chk(sclOe, 0, "lo release");
      if (k == 0)
      begin
        m.restart();
        m.wrBits(hb(10'h2a5, 1));
        m.ackSlot(a);
        w();
        chk({a, status.readWrite}, 2'b01, "10-bit read");
        d = 8'($urandom);
        sw(cm(2, 0));
        sw(cm(1, d));
        sw(cm(3, 0));
        m.rdBits(0, 1, rb);
        chk(rb, d, "10-bit data");
      end
      m.stop();
      sw(cm(2, 0));
    end
    // Collision while sending read data
    @(negedge clk) ctrl.tenBitMode = 1'b0;
    ctrl.slaveCollisionDetectEnable = 1'b1;
    // Own address still holds the 10-bit value; restore the 7-bit one
    sw(cm(0, 8'h52));
    m.start();
    m.wrBits(8'h53);
    m.ackSlot(a);
    sw(cm(2, 0));
    sw(cm(1, 8'hff));
    sw(cm(3, 0));
    m.rdBits(1, 1, rb);
    w();
    chk(status.busCollisionIrq, 1, "collision");
    m.stop();
    sw(cm(4, 0));
    chk(stuck, 0, "scl stuck");
    chk({sclLvl, sdaLvl}, 0, "pin levels");
    results();
  end
endmodule
`default_nettype wire
